/* File: common/cpsf_defines.svh */
// constants of the camera parallel-to-serial framer
// assumes a 200 MHz system clock; included by bare name
`ifndef CPSF_DEFINES_SVH
`define CPSF_DEFINES_SVH

// ----------------------------------------------------------------
// widths and limits
// ----------------------------------------------------------------
`define CPSF_PIX_W       8
`define CPSF_LCNT_W      11
`define CPSF_MAX_LINES   11'd2046
`define CPSF_FIFO_DEPTH  2
`define CPSF_BYTE_LAST   3'd7
`define CPSF_TOK_PIX_IDX 3'd4
`define CPSF_TOK_COD_END 3'd3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CPSF_CLK_MHZ     200
`define CPSF_SLEEP_NS    1000
`define CPSF_SLEEP_CYC   ((`CPSF_SLEEP_NS * `CPSF_CLK_MHZ) / 1000)
`define CPSF_HALF_BIT    1

// ----------------------------------------------------------------
// sync code bytes and data patterns
// ----------------------------------------------------------------
`define CPSF_SYNC_LEAD   8'hff
`define CPSF_SYNC_ZERO   8'h00
`define CPSF_ID_SOL      8'h00
`define CPSF_ID_EOL      8'h01
`define CPSF_ID_SOF      8'h02
`define CPSF_ID_EOF      8'h03
`define CPSF_IDLE_BYTE   8'hff
`define CPSF_STUFF_BYTE  8'h01
`define CPSF_ONES_HI7    7'h7f

`endif

/* File: common/cpsf_pkg.sv */
// types shared by the camera parallel-to-serial framer files
// assumes nothing beyond a SystemVerilog compiler
package cpsf_pkg;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef logic [7:0] cpsf_pix_t;          // one camera byte

	typedef enum logic [1:0] {
		CPSF_SOL,
		CPSF_EOL,
		CPSF_SOF,
		CPSF_EOF
	} cpsf_code_e;                           // sync code kinds

	typedef struct packed {
		logic      fv;                       // frame valid sample
		logic      lv;                       // line valid sample
		cpsf_pix_t data;                     // pixel sample
	} cpsf_word_s;

	typedef struct packed {
		logic       has_code;                // four code bytes first
		cpsf_code_e code;
		logic       has_pix;                 // then one pixel byte
		cpsf_pix_t  pix;
	} cpsf_token_s;

endpackage

/* File: core/cpsf_fifo2.sv */
// small valid/ready buffer between framer and serializer
// assumes one clock; out_data is the head entry's flop content
`timescale 1ns/1ps

module cpsf_fifo2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             reset,
	input  wire logic             clock_enable,
	// filling side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ------------------------------------------------------------
	// storage and pointers
	// ------------------------------------------------------------
	logic [WIDTH-1:0] mem_q [DEPTH];        // entries
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [AW-1:0]    wr_q, wr_d;           // write pointer
	logic [AW-1:0]    rd_q, rd_d;           // read pointer
	logic [AW:0]      cnt_q, cnt_d;         // fill level
	logic             push, pop;

	// honest flags straight from the fill level
	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// next pointers, wrap at depth
	always_comb begin
		mem_d = mem_q;
		wr_d  = wr_q;
		rd_d  = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wr_q] = in_data;
			wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// registers only; clock enable freezes everything
	always_ff @(posedge clock) begin
		if (reset) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else if (clock_enable) begin
			wr_q  <= wr_d;
			rd_q  <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// data entries need no reset, guarded by the count
	always_ff @(posedge clock) begin
		if (clock_enable) begin
			mem_q <= mem_d;
		end
	end

endmodule // cpsf_fifo2

/* File: core/cpsf_framer.sv */
// camera parallel-to-serial framer: capture, framing, serializer
// assumes pixel clock at most a quarter of the system clock rate
`timescale 1ns/1ps
`include "cpsf_defines.svh"

// Contract
// R1: capture pixel byte on pixel clock falling edge
// R2: derive and insert frame and line codes
// R3: serial clock is eight bits per byte
// R4: count lines per frame, up to 2046
// R5: mode high: end frame at line limit
// R6: mode high: extra lines flag an error
// R7: transmit enable low shuts device down
// R8: stopped pixel clock enters standby, resumes
// R9: blanking holds serial data high
// R10: data changes on falling edge, LSB first
// R11: codes are ff 00 00 then kind byte
// R12: ones then sixteen zeros: force 0x01
// R13: serial clock free running while operating
// R14: mode low: no forced end, no error
module cpsf_framer #(
	parameter int HALF_BIT  = `CPSF_HALF_BIT,   // sys cycles per half bit
	parameter int SLEEP_CYC = `CPSF_SLEEP_CYC,  // idle cycles to standby
	parameter int MAX_LINES = `CPSF_MAX_LINES   // line limit per frame
) (
	// system clock and reset
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              clock_enable,
	// camera side
	input  wire logic              pixel_clock_in,
	input  wire cpsf_pkg::cpsf_pix_t pixel_data_in,
	input  wire logic              frame_valid_in,
	input  wire logic              line_valid_in,
	// control pins
	input  wire logic              transmit_enable_pin,
	input  wire logic              frame_limit_mode_pin,
	// serial link
	output logic                   ser_clk_out,
	output logic                   ser_data_out,
	output logic                   ser_drive_n,
	// status
	output logic                   line_limit_error,
	output logic                   standby_active
);
	import cpsf_pkg::*;

	// line limit cut to the counter width on purpose
	localparam int            LW     = `CPSF_LCNT_W;
	localparam logic [LW-1:0] LIM    = MAX_LINES[LW-1:0];
	localparam logic [LW-1:0] LIM_M1 = LIM - 1'b1;

	// ------------------------------------------------------------
	// pixel clock domain: capture and toggle
	// ------------------------------------------------------------
	logic       px_rst_meta_q, px_rst_q;   // reset brought over
	cpsf_word_s px_word_q, px_word_d;      // captured sample
	logic       px_tog_q, px_tog_d;        // flips per sample

	// every falling edge makes one sample
	always_comb begin
		px_word_d = '{fv: frame_valid_in, lv: line_valid_in,
			data: pixel_data_in};                       // [R1]
		px_tog_d  = ~px_tog_q;
	end

	// falling edge capture; reset synchronised into this domain
	always_ff @(negedge pixel_clock_in) begin
		px_rst_meta_q <= reset;
		px_rst_q      <= px_rst_meta_q;
		if (px_rst_q) begin
			px_word_q <= '0;
			px_tog_q  <= 1'b0;
		end else begin
			px_word_q <= px_word_d;                     // [R1]
			px_tog_q  <= px_tog_d;
		end
	end

	// ------------------------------------------------------------
	// synchronisers into the system clock
	// ------------------------------------------------------------
	logic [2:0] sy_meta_q, sy_q;           // toggle, enable, mode
	logic       tog_s, transmit_enable_pin_s, mode_s;

	// two flops each; the first is read by the second only
	always_ff @(posedge clock) begin
		if (reset) begin
			sy_meta_q <= '0;
			sy_q      <= '0;
		end else if (clock_enable) begin
			sy_meta_q <= {px_tog_q, transmit_enable_pin,
				frame_limit_mode_pin};
			sy_q      <= sy_meta_q;
		end
	end
	assign {tog_s, transmit_enable_pin_s, mode_s} = sy_q;

	// ------------------------------------------------------------
	// framer: codes, line count, limit, stuffing
	// ------------------------------------------------------------
	logic                    tog_seen_q, tog_seen_d;  // last handled
	logic                    fv_q, fv_d, lv_q, lv_d;  // previous sample
	logic                    first_q, first_d;        // next line first
	logic                    closed_q, closed_d;      // frame cut short
	logic                    err_q, err_d;            // too many lines
	logic [`CPSF_LCNT_W-1:0] cnt_q, cnt_d;            // lines sent
	cpsf_pix_t               p1_q, p1_d, p2_q, p2_d;  // byte history
	cpsf_token_s             pend_q, pend_d;          // waiting token
	logic                    pend_v_q, pend_v_d;
	logic                    fifo_in_ready;
	logic                    ev_pend, ev_take;
	logic                    line_end, frame_end, line_start, in_line;
	logic                    stuff;
	cpsf_pix_t               h1, h2;
	cpsf_token_s             tok;
	cpsf_word_s              ev_word;

	// the sample stays put for a pixel period after the toggle
	assign ev_word    = px_word_q;
	assign ev_pend    = tog_s ^ tog_seen_q;
	// a stalled token holds the next sample back; a pixel clock fall before it is taken loses it
	assign ev_take    = ev_pend && (!pend_v_q || fifo_in_ready);
	assign in_line    = ev_word.fv && ev_word.lv;
	assign line_end   = lv_q && !in_line && !closed_q;
	assign frame_end  = fv_q && !ev_word.fv && !closed_q;
	assign line_start = in_line && !lv_q;
	// history starts clean at every line
	assign h1 = line_start ? `CPSF_SYNC_ZERO : p1_q;
	assign h2 = line_start ? `CPSF_SYNC_ZERO : p2_q;
	assign stuff = (ev_word.data == `CPSF_SYNC_ZERO) &&
		(((h1 == `CPSF_SYNC_ZERO) && (h2 == `CPSF_SYNC_LEAD)) ||
		((h1 == `CPSF_STUFF_BYTE) &&
		(h2[7:1] == `CPSF_ONES_HI7)));                     // [R12]

	// next framing state per taken sample
	always_comb begin
		tog_seen_d = ev_take ? tog_s : tog_seen_q;
		fv_d     = fv_q;
		lv_d     = lv_q;
		first_d  = first_q;
		closed_d = closed_q;
		err_d    = err_q;
		cnt_d    = cnt_q;
		p1_d     = p1_q;
		p2_d     = p2_q;
		pend_d   = pend_q;
		pend_v_d = pend_v_q && !fifo_in_ready;
		tok      = '0;
		if (!transmit_enable_pin_s) begin
			// shutdown forgets the frame in progress
			fv_d     = 1'b0;
			lv_d     = 1'b0;
			first_d  = 1'b1;
			closed_d = 1'b0;
			cnt_d    = '0;
			pend_v_d = 1'b0;                            // [R7]
		end else if (ev_take) begin
			if (frame_end) begin
				tok.has_code = 1'b1;
				tok.code     = CPSF_EOF;                // [R2]
			end else if (line_end) begin
				if (cnt_q != LIM) begin
					cnt_d = cnt_q + 1'b1;               // [R4]
				end
				tok.has_code = 1'b1;
				if (mode_s &&
					cnt_q == LIM_M1) begin
					tok.code = CPSF_EOF;                // [R5]
					closed_d = 1'b1;
				end else begin
					tok.code = CPSF_EOL;                // [R14]
				end
			end
			if (line_start) begin
				if (closed_q) begin
					err_d = err_q || mode_s;            // [R6]
				end else begin
					tok.has_code = 1'b1;
					tok.code = first_q ? CPSF_SOF : CPSF_SOL;
					first_d  = 1'b0;                    // [R2]
				end
			end
			if (in_line && !closed_q) begin
				tok.has_pix = 1'b1;
				tok.pix = stuff ? `CPSF_STUFF_BYTE : ev_word.data;
				p2_d = h1;
				p1_d = ev_word.data;
			end
			if (!ev_word.fv) begin
				first_d  = 1'b1;
				closed_d = 1'b0;
				cnt_d    = '0;
			end
			if (ev_word.fv && !fv_q) begin
				err_d = 1'b0;                           // new frame
			end
			fv_d = ev_word.fv;
			lv_d = ev_word.lv;
			if (tok.has_code || tok.has_pix) begin
				pend_d   = tok;
				pend_v_d = 1'b1;
			end
		end
	end

	// framer registers
	always_ff @(posedge clock) begin
		if (reset) begin
			tog_seen_q <= 1'b0;
			fv_q       <= 1'b0;
			lv_q       <= 1'b0;
			first_q    <= 1'b1;
			closed_q   <= 1'b0;
			err_q      <= 1'b0;
			cnt_q      <= '0;
			p1_q       <= '0;
			p2_q       <= '0;
			pend_q     <= '0;
			pend_v_q   <= 1'b0;
		end else if (clock_enable) begin
			tog_seen_q <= tog_seen_d;
			fv_q       <= fv_d;
			lv_q       <= lv_d;
			first_q    <= first_d;
			closed_q   <= closed_d;
			err_q      <= err_d;
			cnt_q      <= cnt_d;
			p1_q       <= p1_d;
			p2_q       <= p2_d;
			pend_q     <= pend_d;
			pend_v_q   <= pend_v_d;
		end
	end
	assign line_limit_error = err_q;

	// ------------------------------------------------------------
	// two-entry buffer between framer and serializer
	// ------------------------------------------------------------
	logic        fifo_out_valid, fifo_out_ready;
	cpsf_token_s fifo_out;

	cpsf_fifo2 #(
		.WIDTH ($bits(cpsf_token_s)),
		.DEPTH (`CPSF_FIFO_DEPTH)
	) u_buf (
		.clock        (clock),
		.reset        (reset),
		.clock_enable (clock_enable),
		.in_valid     (pend_v_q),
		.in_ready     (fifo_in_ready),
		.in_data      (pend_q),
		.out_valid    (fifo_out_valid),
		.out_ready    (fifo_out_ready),
		.out_data     (fifo_out)
	);

	// ------------------------------------------------------------
	// standby watch and serializer
	// ------------------------------------------------------------
	logic [11:0]   idle_q, idle_d;          // cycles without sample
	logic          stby_q, stby_d;
	logic [7:0]    half_q, half_d;          // half bit divider
	logic          clk_q, clk_d, dat_q, dat_d, drv_n_q, drv_n_d;
	logic [2:0]    bit_q, bit_d, idx_q, idx_d;
	cpsf_pix_t     sh_q, sh_d;              // byte being shifted
	cpsf_token_s   cur_q, cur_d;            // token being sent
	logic          have_q, have_d;
	logic          active, tick, fall;

	// byte of a token: lead, zero, zero, kind, then pixel
	function automatic cpsf_pix_t tok_byte(cpsf_token_s t,
		logic [2:0] i);
		cpsf_pix_t b;
		case (i)
			3'd0: b = `CPSF_SYNC_LEAD;
			3'd1, 3'd2: b = `CPSF_SYNC_ZERO;
			3'd3: begin
				case (t.code)
					CPSF_SOL: b = `CPSF_ID_SOL;
					CPSF_EOL: b = `CPSF_ID_EOL;
					CPSF_SOF: b = `CPSF_ID_SOF;
					default:  b = `CPSF_ID_EOF;
				endcase
			end
			default: b = t.pix;
		endcase
		return b;                                      // [R11]
	endfunction

	assign active = transmit_enable_pin_s && !stby_q;
	assign tick   = (half_q == 8'(HALF_BIT - 1));
	assign fall   = active && tick && clk_q;
	assign fifo_out_ready = active && !have_q && fifo_out_valid;

	// next serializer state
	always_comb begin
		idle_d  = ev_pend ? '0 : idle_q + {11'd0, (idle_q != 12'(SLEEP_CYC))};
		stby_d  = !ev_pend && (idle_q == 12'(SLEEP_CYC));  // [R8]
		half_d  = '0;
		clk_d   = 1'b0;
		dat_d   = 1'b1;
		drv_n_d = 1'b1;
		bit_d   = bit_q;
		idx_d   = idx_q;
		sh_d    = sh_q;
		cur_d   = cur_q;
		have_d  = have_q;
		if (active) begin
			drv_n_d = 1'b0;
			dat_d   = dat_q;
			half_d  = tick ? '0 : half_q + 1'b1;
			clk_d   = tick ? ~clk_q : clk_q;           // [R13] [R3]
			if (fifo_out_ready) begin
				cur_d  = fifo_out;
				have_d = 1'b1;
				idx_d  = fifo_out.has_code ? 3'd0 : `CPSF_TOK_PIX_IDX;
			end
			if (fall) begin
				dat_d = sh_q[0];                        // [R10]
				if (bit_q == `CPSF_BYTE_LAST) begin
					bit_d = '0;
					if (have_q) begin
						sh_d = tok_byte(cur_q, idx_q);  // [R2]
						if (idx_q == `CPSF_TOK_PIX_IDX ||
							(idx_q == `CPSF_TOK_COD_END &&
							!cur_q.has_pix)) begin
							have_d = 1'b0;
						end else begin
							idx_d = idx_q + 1'b1;
						end
					end else begin
						sh_d = `CPSF_IDLE_BYTE;         // [R9]
					end
				end else begin
					bit_d = bit_q + 1'b1;
					sh_d  = {1'b1, sh_q[7:1]};
				end
			end
		end else begin
			bit_d = '0;
			sh_d  = `CPSF_IDLE_BYTE;
		end
	end

	// serializer registers
	always_ff @(posedge clock) begin
		if (reset) begin
			idle_q  <= '0;
			stby_q  <= 1'b0;
			half_q  <= '0;
			clk_q   <= 1'b0;
			dat_q   <= 1'b1;
			drv_n_q <= 1'b1;
			bit_q   <= '0;
			idx_q   <= '0;
			sh_q    <= `CPSF_IDLE_BYTE;
			cur_q   <= '0;
			have_q  <= 1'b0;
		end else if (clock_enable) begin
			idle_q  <= idle_d;
			stby_q  <= stby_d;
			half_q  <= half_d;
			clk_q   <= clk_d;
			dat_q   <= dat_d;
			drv_n_q <= drv_n_d;
			bit_q   <= bit_d;
			idx_q   <= idx_d;
			sh_q    <= sh_d;
			cur_q   <= cur_d;
			have_q  <= have_d;
		end
	end
	assign ser_clk_out    = clk_q;
	assign ser_data_out   = dat_q;
	assign ser_drive_n    = drv_n_q;
	assign standby_active = stby_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset || !clock_enable);

	// in mode high, a line end at the limit line, frame valid still high, sends end of frame and closes the frame
	sequence s_limit_line;
		ev_take && transmit_enable_pin_s && line_end && mode_s && ev_word.fv &&
			cnt_q == LIM_M1;
	endsequence

	line_count_a: assert property (cnt_q <= LIM) // [R4]
		else $error("line count above limit");
	limit_eof_a: assert property (s_limit_line |=>          // [R5]
		pend_v_q && pend_q.code == CPSF_EOF && closed_q)
		else $error("no end of frame at line limit");
	extra_line_a: assert property (ev_take && transmit_enable_pin_s &&     // [R6]
		line_start && closed_q && mode_s |=> line_limit_error)
		else $error("extra line not flagged");
	no_limit_a: assert property (!mode_s && clock_enable    // [R14]
		|=> !$rose(closed_q) && !$rose(err_q))
		else $error("limit acted with mode low");
	shutdown_a: assert property (!transmit_enable_pin_s |=>                // [R7]
		ser_drive_n && !ser_clk_out && ser_data_out)
		else $error("outputs live in shutdown");
	standby_a: assert property ((!ev_pend)[*2] ##0          // [R8]
		idle_q == 12'(SLEEP_CYC) |=> standby_active)
		else $error("standby not entered");
	free_clock_a: assert property (active && tick ##1 active // [R13]
		|-> ser_clk_out != $past(ser_clk_out))
		else $error("serial clock did not toggle");
	fall_data_a: assert property (active && $changed(ser_data_out)
		|-> $past(fall))                                 // [R10]
		else $error("data moved off a falling edge");
	idle_high_a: assert property (fall && sh_q == `CPSF_IDLE_BYTE
		|=> ser_data_out)                                // [R9]
		else $error("idle bit not high");
	stuff_a: assert property (ev_take && transmit_enable_pin_s && stuff &&  // [R12]
		in_line && !closed_q |=> pend_q.pix == `CPSF_STUFF_BYTE)
		else $error("pattern byte not forced");

endmodule // cpsf_framer

/* File: bench/cpsf_rx_model.sv */
// receiver model standing on the far side of the framer's serial link
// assumes every burst after an enable opens with a sync code
`timescale 1ns/1ps

module cpsf_rx_model (
	// serial link from the framer
	input  wire logic ser_clk_out,
	input  wire logic ser_data_out,
	input  wire logic ser_drive_n
);
	// ----------------------------------------------------------------
	// receive state
	// ----------------------------------------------------------------
	logic [31:0] sr_q;     // last 32 bits, newest on top
	logic        lock_q;   // byte boundary found
	int          nbit_q;   // bits into the current byte
	logic [7:0]  got_q[$]; // non-idle bytes handed to the bench

	initial sr_q = '1;
	initial lock_q = 1'b0;
	initial nbit_q = 0;

	// link released: boundary lost, ones so stale bits never match
	always @(posedge ser_drive_n) begin
		lock_q = 1'b0;
		sr_q = '1;
	end

	// sample on the rising serial clock edge, lsb arrives first
	always @(posedge ser_clk_out) begin
		if (!ser_drive_n) begin
			sr_q = {ser_data_out, sr_q[31:1]};
			nbit_q = nbit_q + 1;
			// eight ones then sixteen zeros mark a byte boundary
			if (!lock_q && sr_q[23:0] == 24'h0000ff) begin
				lock_q = 1'b1;
				nbit_q = 0;
				got_q.push_back(8'h00);
				got_q.push_back(8'h00);
				got_q.push_back(sr_q[31:24]);
			end else if (lock_q && nbit_q == 8) begin
				nbit_q = 0;
				// idle fill and code leads are dropped, so 0xff pixels
				// cannot be told apart: the bench leaves them out of its expected bytes
				if (sr_q[31:24] != 8'hff)
					got_q.push_back(sr_q[31:24]);
			end
		end
	end
endmodule // cpsf_rx_model

/* File: bench/testbench.sv */
// self-checking bench for the camera parallel-to-serial framer
// assumes cpsf_pkg and the receiver model are compiled first
`timescale 1ns/1ps

module testbench;
	import cpsf_pkg::*;

	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic      clock = 1'b0;               // 200 MHz system clock
	logic      reset = 1'b1;               // sync, active high
	logic      pixel_clock_in = 1'b0;      // still between samples
	cpsf_pix_t pixel_data_in = 8'h00;      // camera byte
	logic      frame_valid_in = 1'b0;      // frame level
	logic      line_valid_in = 1'b0;       // line level
	logic      transmit_enable_pin = 1'b1; // operate
	logic      frame_limit_mode_pin = 1'b0;
	logic      ser_clk_out;
	logic      ser_data_out;
	logic      ser_drive_n;
	logic      line_limit_error;
	logic      standby_active;
	int        n_errors = 0;
	int        n_compared = 0;
	localparam int LINES = 2;              // short limit keeps cut in reach

	always #2.5 clock = ~clock;

	cpsf_framer #(
		.MAX_LINES (LINES)
	) i_cpsf_framer (
		.clock                (clock),
		.reset                (reset),
		.clock_enable         (1'b1),
		.pixel_clock_in       (pixel_clock_in),
		.pixel_data_in        (pixel_data_in),
		.frame_valid_in       (frame_valid_in),
		.line_valid_in        (line_valid_in),
		.transmit_enable_pin  (transmit_enable_pin),
		.frame_limit_mode_pin (frame_limit_mode_pin),
		.ser_clk_out          (ser_clk_out),
		.ser_data_out         (ser_data_out),
		.ser_drive_n          (ser_drive_n),
		.line_limit_error     (line_limit_error),
		.standby_active       (standby_active)
	);

	cpsf_rx_model u_rx (
		.ser_clk_out  (ser_clk_out),
		.ser_data_out (ser_data_out),
		.ser_drive_n  (ser_drive_n)
	);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	// print counts and verdict, end the run
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// compare one value, count it, report a miss
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one camera sample: one 15 ns pixel clock pulse, then a rest long
	// enough for a code plus a byte to drain (the link is 1 byte/80 ns)
	task automatic samp(input logic fv, input logic lv, input cpsf_pix_t d);
		@(posedge clock);
		frame_valid_in <= fv;
		line_valid_in <= lv;
		pixel_data_in <= d;
		#4 pixel_clock_in = 1'b1;
		#15 pixel_clock_in = 1'b0; // capture edge
		#11;
		repeat (100) @(posedge clock);
	endtask

	// wait, bounded, for the receiver's bytes and compare them in order
	task automatic expect_bytes(input logic [7:0] exp[$]);
		int i;
		for (i = 0; i < 3000 && u_rx.got_q.size() < exp.size(); i++)
			@(posedge clock);
		if (u_rx.got_q.size() < exp.size()) begin
			n_errors++;
			$display("BAD %0t receiver starved", $time);
			give_verdict();
		end
		chk(8'(u_rx.got_q.size()), 8'(exp.size()));
		foreach (exp[k])
			chk(u_rx.got_q[k], exp[k]);
		u_rx.got_q.delete();
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// mode low, two lines meet the limit: still eol, no cut, no error
	task automatic t_frame();
		logic [7:0] q[$];
		frame_limit_mode_pin <= 1'b0;
		samp(1'b1, 1'b1, 8'h11);
		samp(1'b1, 1'b1, 8'h22);
		samp(1'b1, 1'b0, 8'h5a);
		samp(1'b1, 1'b1, 8'h33);
		samp(1'b1, 1'b0, 8'h5a);
		samp(1'b0, 1'b0, 8'h5a);
		q = '{8'h00, 8'h00, 8'h02, 8'h11, 8'h22, 8'h00, 8'h00, 8'h01,
			8'h00, 8'h00, 8'h00, 8'h33, 8'h00, 8'h00, 8'h01,
			8'h00, 8'h00, 8'h03};
		expect_bytes(q);
		chk({7'h0, line_limit_error}, 8'h00);
		$display("frame test done");
	endtask

	// blanking with zero data: line high, clock keeps toggling
	task automatic t_blank();
		logic prev;
		samp(1'b0, 1'b0, 8'h00);
		#1 prev = ser_clk_out;
		repeat (8) begin
			@(posedge clock);
			#1;
			chk({7'h0, ser_data_out}, 8'h01);
			chk({7'h0, ser_clk_out}, {7'h0, ~prev});
			chk({7'h0, ser_drive_n}, 8'h00);
			prev = ser_clk_out;
		end
		chk(8'(u_rx.got_q.size()), 8'h00);
		$display("blanking test done");
	endtask

	// shutdown: outputs parked, samples dropped, then back to work
	task automatic t_shutdown();
		transmit_enable_pin <= 1'b0;
		repeat (10) @(posedge clock);
		#1;
		chk({5'h0, ser_drive_n, ser_clk_out, ser_data_out}, 8'h05);
		samp(1'b1, 1'b1, 8'h44);
		samp(1'b0, 1'b0, 8'h44);
		transmit_enable_pin <= 1'b1;
		repeat (10) @(posedge clock);
		#1;
		chk({7'h0, ser_drive_n}, 8'h00);
		chk(8'(u_rx.got_q.size()), 8'h00);
		$display("shutdown test done");
	endtask

	// ones then sixteen zeros in pixels: the second zero becomes one
	task automatic t_stuff();
		logic [7:0] q[$];
		frame_limit_mode_pin <= 1'b1;
		samp(1'b1, 1'b1, 8'hff);
		samp(1'b1, 1'b1, 8'h00);
		samp(1'b1, 1'b1, 8'h00);
		samp(1'b0, 1'b0, 8'h00);
		q = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h00, 8'h03};
		expect_bytes(q);
		$display("stuffing test done");
	endtask

	// mode high: limit line ends with eof, a later line flags the error
	task automatic t_limit();
		logic [7:0] q[$];
		frame_limit_mode_pin <= 1'b1;
		samp(1'b1, 1'b1, 8'ha1);
		samp(1'b1, 1'b0, 8'h5a);
		samp(1'b1, 1'b1, 8'ha2);
		samp(1'b1, 1'b0, 8'h5a); // limit line ends
		samp(1'b1, 1'b1, 8'ha3); // extra line, dropped
		samp(1'b1, 1'b0, 8'h5a);
		samp(1'b0, 1'b0, 8'h5a);
		chk({7'h0, line_limit_error}, 8'h01);
		samp(1'b1, 1'b1, 8'hb1);
		samp(1'b0, 1'b0, 8'h5a);
		chk({7'h0, line_limit_error}, 8'h00);
		q = '{8'h00, 8'h00, 8'h02, 8'ha1, 8'h00, 8'h00, 8'h01,
			8'h00, 8'h00, 8'h00, 8'ha2, 8'h00, 8'h00, 8'h03,
			8'h00, 8'h00, 8'h02, 8'hb1, 8'h00, 8'h00, 8'h03};
		expect_bytes(q);
		$display("limit test done");
	endtask

	// pixel clock stops: standby with parked link, a sample wakes it
	task automatic t_standby();
		repeat (300) @(posedge clock);
		#1;
		chk({standby_active, ser_drive_n, ser_clk_out, ser_data_out},
			8'h0d);
		samp(1'b0, 1'b0, 8'h00);
		#1;
		chk({6'h0, standby_active, ser_drive_n}, 8'h00);
		$display("standby test done");
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	// reset spans three pixel clock falls so both domains clear, and
	// two idle falls after release let the pixel-side reset go
	initial begin
		repeat (2) @(posedge clock);
		repeat (3) samp(1'b0, 1'b0, 8'h00);
		#1;
		chk({3'h0, line_limit_error, standby_active, ser_drive_n,
			ser_clk_out, ser_data_out}, 8'h05);
		@(posedge clock);
		reset <= 1'b0;
		repeat (4) @(posedge clock);
		repeat (2) samp(1'b0, 1'b0, 8'h00);
		t_frame();
		t_blank();
		t_shutdown();
		t_stuff();
		t_limit();
		t_standby();
		give_verdict();
	end
endmodule // testbench
